// file: common/cfaf_pkg.sv
/*
 * Constants shared by the communication fault alert flag block: the bit
 * positions of the alert flags in the first alert status register, their
 * reset value, the host interface encoding and the measurement figures of
 * the SPI frame check and the fast oscillator drift check.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package cfaf_pkg;

	// Width of the first alert status register byte held by this block.
	localparam int unsigned FLAG_WIDTH = 8;

	// Bit positions of the alert flags.
	localparam int unsigned BIT_PROT_REJECT   = 0;
	localparam int unsigned BIT_I2C_FAULT     = 2;
	localparam int unsigned BIT_INT_BUS_FAIL  = 4;
	localparam int unsigned BIT_OSC_DRIFT     = 5;
	localparam int unsigned BIT_SCLK_COUNT    = 6;
	localparam int unsigned BIT_SPI_SUMMARY   = 7;

	// Reset value of every alert flag.
	localparam logic FLAG_RESET = 1'b0;

	// Host interface select value that chooses the SPI host interface.
	localparam logic HOST_IF_SPI = 1'b0;

	// Serial clock cycles in a well formed SPI transaction.
	localparam int unsigned SPI_FRAME_CLOCKS = 32;

	// Width of the serial clock counter; it saturates at its top value.
	localparam int unsigned SCLK_CNT_WIDTH = 6;

	// Number of error indicator bits in the I2C status register.
	localparam int unsigned I2C_ERR_WIDTH = 9;

	// Slow oscillator cycles in one drift measurement window.
	localparam int unsigned OSC_WINDOW_CYCLES = 2;

	// Allowed deviation of the fast oscillator, in percent.
	localparam int unsigned OSC_TOL_PERCENT = 5;

	// Expected fast oscillator edges in one window; plain default.
	localparam int unsigned OSC_EXPECTED_COUNT = 1000;

	// Width of the fast oscillator edge counter.
	localparam int unsigned OSC_CNT_WIDTH = 12;

endpackage

// file: hdl/cfaf_osc_monitor.sv
/*
 * Fast oscillator drift monitor. It counts fast oscillator edges over a
 * window of slow oscillator cycles and reports whether the count lies
 * within the allowed tolerance of the expected value.
 * Assumes both edge inputs are one-cycle pulses already synchronised to
 * clk, and that clk is fast enough to see every fast oscillator edge.
 */
`timescale 1ns/100ps

module cfaf_osc_monitor #(
	parameter int unsigned EXPECTED_COUNT = cfaf_pkg::OSC_EXPECTED_COUNT,
	parameter int unsigned CNT_WIDTH      = cfaf_pkg::OSC_CNT_WIDTH
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Measurement control and edge pulses.
	input  wire logic enable,
	input  wire logic fast_edge,
	input  wire logic slow_edge,
	// Drift status, refreshed at the end of each window except the first after enabling.
	output logic      drift
);

	localparam int unsigned TOL   = (EXPECTED_COUNT * cfaf_pkg::OSC_TOL_PERCENT) / 100;
	localparam int unsigned LIMIT_LO = EXPECTED_COUNT - TOL;
	localparam int unsigned LIMIT_HI = EXPECTED_COUNT + TOL;
	localparam int unsigned LAST_PHASE = cfaf_pkg::OSC_WINDOW_CYCLES - 1;

	logic [CNT_WIDTH-1:0] fast_count;
	logic [CNT_WIDTH-1:0] next_fast_count;
	logic [1:0]           phase;
	logic [1:0]           next_phase;
	logic                 armed;
	logic                 next_armed;
	logic                 next_drift;

	// Tells whether an edge count lies inside the tolerance band.
	function automatic logic in_band(input logic [CNT_WIDTH-1:0] c);
		int unsigned v;
		v = int'(c);
		return (v >= LIMIT_LO) && (v <= LIMIT_HI);
	endfunction

	// Counts fast edges and closes the window on every second slow edge.
	always_comb begin
		next_fast_count = fast_count;
		next_phase      = phase;
		next_armed      = armed;
		next_drift      = drift;
		if (!enable) begin
			next_fast_count = '0;
			next_phase      = '0;
			next_armed      = 1'b0;
			next_drift      = 1'b0;
		end else begin
			if (fast_edge && (fast_count != {CNT_WIDTH{1'b1}})) begin
				next_fast_count = fast_count + 1'b1;
			end
			if (slow_edge) begin
				if (phase == 2'(LAST_PHASE)) begin
					// The first window after enabling is partial and not judged.
					if (armed) begin
						next_drift = !in_band(fast_count); // [R05] [R06]
					end
					next_armed      = 1'b1;
					next_fast_count = {{(CNT_WIDTH-1){1'b0}}, fast_edge};
					next_phase      = '0;
				end else begin
					next_phase = phase + 2'h1;
				end
			end
		end
	end

	// Registers the measurement state.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fast_count <= '0;
			phase      <= '0;
			armed      <= 1'b0;
			drift      <= 1'b0;
		end else begin
			fast_count <= next_fast_count;
			phase      <= next_phase;
			armed      <= next_armed;
			drift      <= next_drift;
		end
	end

endmodule

// file: hdl/cfaf_top.sv
/*
 * Communication fault alert flags: the SPI clock count check, the fast
 * oscillator drift check, the internal bus failure, the I2C controller
 * fault summary, the protected write rejection and the SPI error summary
 * with its CRC flag, together with the status bit sent in every SPI frame.
 * Assumes the SPI serial clock runs only while the chip select is low,
 * that the oscillator and SPI pins are asynchronous to CORE_CLK, and that all
 * other inputs come from logic on CORE_CLK.
 */
`timescale 1ns/100ps

// Function
// R01 - A SPI frame that does not hold exactly 32 serial clocks sets the clock count alert, bit 6.
// R02 - The clock count, oscillator drift and internal bus alerts together form status bit 1.
// R03 - The clock count and internal bus alerts clear on a written 0 and ignore a written 1.
// R04 - The clock count and internal bus alerts work only while the SPI interface is selected.
// R05 - The drift alert, bit 5, sets when the fast oscillator is off by more than 5 percent.
// R06 - The drift status is refreshed every two slow cycles and checked only in SPI mode.
// R07 - A written 0 clears the drift alert only once the drift has gone away.
// R08 - A failed SPI transfer over the internal bus sets the internal bus alert, bit 4.
// R09 - The I2C fault flag, bit 2, is the masked OR of the nine I2C status error bits.
// R10 - The I2C fault flag is read only and falls when all unmasked errors are gone.
// R11 - A protected write during a scan or balancing is dropped and sets bit 0 until a written 0.
// R12 - A CRC error shows only in the CRC flag, which a written 0 to the summary bit clears.
// R13 - A written 0 to the summary bit clears CRC, mismatch and timeout errors alike.
// R14 - A written 0 clears a flag only until its fault recurs, and a set beats a clear.
module cfaf_top #(
	parameter int unsigned OSC_EXPECTED_COUNT = cfaf_pkg::OSC_EXPECTED_COUNT
) (
	// Core clock and reset.
	input  wire logic                               CORE_CLK,
	input  wire logic                               RESET,
	// SPI link clock and frame select.
	input  wire logic                               SPI_SCLK,
	input  wire logic                               SPI_CS_N,
	// Oscillator pins.
	input  wire logic                               FAST_OSC_IN,
	input  wire logic                               SLOW_OSC_IN,
	// Configuration.
	input  wire logic                               HOST_IF_SELECT,
	input  wire logic [cfaf_pkg::I2C_ERR_WIDTH-1:0] I2C_STATUS,
	input  wire logic [cfaf_pkg::I2C_ERR_WIDTH-1:0] I2C_ALERT_ENABLE,
	// Fault events from the SPI engine and the internal bus.
	input  wire logic                               INT_BUS_FAIL,
	input  wire logic                               SPI_CRC_ERR,
	input  wire logic                               SPI_RW_ERR,
	input  wire logic                               SPI_TIMEOUT_ERR,
	// Protected register writes.
	input  wire logic                               PROT_WRITE_REQ,
	input  wire logic                               SCAN_ACTIVE,
	input  wire logic                               BALANCE_ACTIVE,
	output logic                                    PROT_WRITE_ACCEPT,
	// Software write to the alert flags.
	input  wire logic                               FLAG_WRITE,
	input  wire logic [cfaf_pkg::FLAG_WIDTH-1:0]    FLAG_WRITE_DATA,
	// Flag read back and frame status.
	output logic [cfaf_pkg::FLAG_WIDTH-1:0]         ALERT_FLAGS,
	output logic                                    SPI_CRC_FAULT_FLAG,
	output logic                                    STAT_BIT1
);

	localparam int unsigned CW = cfaf_pkg::SCLK_CNT_WIDTH;

	// Link domain state.
	logic          link_clear;
	logic          frame_fresh;
	logic [CW-1:0] sclk_count;
	logic [CW-1:0] next_sclk_count;
	logic          frame_toggle;
	logic          next_frame_toggle;

	// Synchronisers into the core domain.
	logic cs_meta;
	logic cs_sync;
	logic cs_last;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic next_tgl_seen;
	logic fast_meta;
	logic fast_sync;
	logic fast_last;
	logic slow_meta;
	logic slow_sync;
	logic slow_last;

	// Alert flags and outputs.
	logic spi_clock_count_alert;
	logic fast_osc_drift_alert;
	logic internal_bus_fail_alert;
	logic i2c_controller_fault_alert;
	logic protected_write_reject_alert;
	logic spi_error_summary_alert;
	logic spi_crc_fault_flag;
	logic next_spi_clock_count_alert;
	logic next_fast_osc_drift_alert;
	logic next_internal_bus_fail_alert;
	logic next_i2c_controller_fault_alert;
	logic next_protected_write_reject_alert;
	logic next_spi_error_summary_alert;
	logic next_spi_crc_fault_flag;
	logic next_stat_bit1;
	logic next_prot_write_accept;

	// Decoded conditions.
	logic spi_mode;
	logic frame_end;
	logic frame_bad;
	logic osc_drift;
	logic prot_blocked;

	// Tells whether a software write asks to clear the flag at a bit.
	// A written 1 never clears, so writing back the value read leaves set flags in the byte alone; a 0 read at bit 7 still clears the CRC flag.
	function automatic logic clear_req(input logic wr,
	                                   input logic [cfaf_pkg::FLAG_WIDTH-1:0] data,
	                                   input int unsigned pos);
		return wr && !data[pos];
	endfunction

	// Saturating increment, so that overlong frames never wrap to 32.
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c);
		return (c == {CW{1'b1}}) ? c : c + 1'b1;
	endfunction

	// The frame marker is preset while the chip select is high, so the
	// first serial clock of a frame restarts the count.
	assign link_clear = RESET | SPI_CS_N;

	always_ff @(posedge SPI_SCLK or posedge link_clear) begin
		if (link_clear) begin
			frame_fresh <= 1'b1;
		end else begin
			frame_fresh <= 1'b0;
		end
	end

	// Counts serial clocks and toggles once at the start of each frame.
	// The toggle, not the count, tells the core domain that a frame had clocks at all,
	// because a frame without any clock would leave the previous count behind.
	always_comb begin
		next_sclk_count   = frame_fresh ? {{(CW-1){1'b0}}, 1'b1} : sat_inc(sclk_count);
		next_frame_toggle = frame_fresh ? !frame_toggle : frame_toggle;
	end

	always_ff @(posedge SPI_SCLK or posedge RESET) begin
		if (RESET) begin
			sclk_count   <= '0;
			frame_toggle <= 1'b0;
		end else begin
			sclk_count   <= next_sclk_count;
			frame_toggle <= next_frame_toggle;
		end
	end

	// Brings the chip select, frame toggle and oscillator pins into the core domain.
	// Each pin passes two flip-flops; the third stage only keeps the old value for edges.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			cs_meta   <= 1'b1;
			cs_sync   <= 1'b1;
			cs_last   <= 1'b1;
			tgl_meta  <= 1'b0;
			tgl_sync  <= 1'b0;
			fast_meta <= 1'b0;
			fast_sync <= 1'b0;
			fast_last <= 1'b0;
			slow_meta <= 1'b0;
			slow_sync <= 1'b0;
			slow_last <= 1'b0;
		end else begin
			cs_meta   <= SPI_CS_N;
			cs_sync   <= cs_meta;
			cs_last   <= cs_sync;
			tgl_meta  <= frame_toggle;
			tgl_sync  <= tgl_meta;
			fast_meta <= FAST_OSC_IN;
			fast_sync <= fast_meta;
			fast_last <= fast_sync;
			slow_meta <= SLOW_OSC_IN;
			slow_sync <= slow_meta;
			slow_last <= slow_sync;
		end
	end

	// Measures the fast oscillator against the slow one in SPI mode only.
	// Leaving SPI mode resets the monitor, so the first window after a return is not judged.
	cfaf_osc_monitor #(
		.EXPECTED_COUNT (OSC_EXPECTED_COUNT),
		.CNT_WIDTH      (cfaf_pkg::OSC_CNT_WIDTH)
	) u_osc_monitor (
		.clk       (CORE_CLK),
		.rst       (RESET),
		.enable    (spi_mode),                // [R06]
		.fast_edge (fast_sync & !fast_last),
		.slow_edge (slow_sync & !slow_last),
		.drift     (osc_drift)
	);

	// Frame end qualifies the link count, which is stable once the serial clock stops.
	// The count word needs no synchroniser of its own: it is read only some core cycles
	// after the chip select rises, long after its last change.
	// A frame without any serial clock leaves the toggle alone and counts as bad.
	assign spi_mode     = (HOST_IF_SELECT == cfaf_pkg::HOST_IF_SPI);
	assign frame_end    = cs_sync & !cs_last;
	assign frame_bad    = (tgl_sync == tgl_seen) ||
	                      (sclk_count != CW'(cfaf_pkg::SPI_FRAME_CLOCKS)); // [R01]
	assign prot_blocked = SCAN_ACTIVE | BALANCE_ACTIVE;

	// Computes every flag; a set in the same cycle as a clear wins.
	always_comb begin
		// Remembers the toggle of the last frame seen, whether it was judged or not.
		next_tgl_seen = frame_end ? tgl_sync : tgl_seen;

		// Clock count alert.
		next_spi_clock_count_alert = (spi_mode && frame_end && frame_bad) || // [R01] [R14]
			(spi_clock_count_alert &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_SCLK_COUNT)); // [R03]
		if (!spi_mode) begin
			next_spi_clock_count_alert = 1'b0; // [R04]
		end

		// Internal bus failure alert.
		next_internal_bus_fail_alert = (spi_mode && INT_BUS_FAIL) || // [R08] [R14]
			(internal_bus_fail_alert &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_INT_BUS_FAIL)); // [R03]
		if (!spi_mode) begin
			next_internal_bus_fail_alert = 1'b0; // [R04]
		end

		// Drift alert holds while the drift lasts, so a clear cannot take.
		next_fast_osc_drift_alert = osc_drift || // [R05] [R07]
			(fast_osc_drift_alert &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_OSC_DRIFT));
		if (!spi_mode) begin
			next_fast_osc_drift_alert = 1'b0;
		end

		// I2C fault follows the masked error bits and ignores writes.
		next_i2c_controller_fault_alert = |(I2C_STATUS & I2C_ALERT_ENABLE); // [R09] [R10]

		// Protected write rejection.
		next_prot_write_accept            = PROT_WRITE_REQ && !prot_blocked; // [R11]
		next_protected_write_reject_alert = (PROT_WRITE_REQ && prot_blocked) || // [R11]
			(protected_write_reject_alert &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_PROT_REJECT));

		// SPI summary takes mismatch and timeout; CRC has its own flag.
		next_spi_error_summary_alert = (spi_mode && (SPI_RW_ERR || SPI_TIMEOUT_ERR)) || // [R12]
			(spi_error_summary_alert &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_SPI_SUMMARY)); // [R13]
		next_spi_crc_fault_flag = (spi_mode && SPI_CRC_ERR) || // [R12] [R14]
			(spi_crc_fault_flag &&
			 !clear_req(FLAG_WRITE, FLAG_WRITE_DATA, cfaf_pkg::BIT_SPI_SUMMARY)); // [R13]

		// Status bit sent in each SPI frame.
		next_stat_bit1 = next_spi_clock_count_alert || next_fast_osc_drift_alert ||
		                 next_internal_bus_fail_alert; // [R02]
	end

	// Registers the flags and the frame bookkeeping.
	// The status bit is taken from the next values so that it moves with the flags.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			tgl_seen                     <= 1'b0;
			spi_clock_count_alert        <= cfaf_pkg::FLAG_RESET;
			fast_osc_drift_alert         <= cfaf_pkg::FLAG_RESET;
			internal_bus_fail_alert      <= cfaf_pkg::FLAG_RESET;
			i2c_controller_fault_alert   <= cfaf_pkg::FLAG_RESET;
			protected_write_reject_alert <= cfaf_pkg::FLAG_RESET;
			spi_error_summary_alert      <= cfaf_pkg::FLAG_RESET;
			spi_crc_fault_flag           <= cfaf_pkg::FLAG_RESET;
			STAT_BIT1                    <= 1'b0;
			PROT_WRITE_ACCEPT            <= 1'b0;
		end else begin
			tgl_seen                     <= next_tgl_seen;
			spi_clock_count_alert        <= next_spi_clock_count_alert;
			fast_osc_drift_alert         <= next_fast_osc_drift_alert;
			internal_bus_fail_alert      <= next_internal_bus_fail_alert;
			i2c_controller_fault_alert   <= next_i2c_controller_fault_alert;
			protected_write_reject_alert <= next_protected_write_reject_alert;
			spi_error_summary_alert      <= next_spi_error_summary_alert;
			spi_crc_fault_flag           <= next_spi_crc_fault_flag;
			STAT_BIT1                    <= next_stat_bit1;
			PROT_WRITE_ACCEPT            <= next_prot_write_accept;
		end
	end

	// Places the flags at their bit positions; unused bits read as zero.
	always_comb begin
		ALERT_FLAGS                                     = '0;
		ALERT_FLAGS[cfaf_pkg::BIT_PROT_REJECT]          = protected_write_reject_alert;
		ALERT_FLAGS[cfaf_pkg::BIT_I2C_FAULT]            = i2c_controller_fault_alert;
		ALERT_FLAGS[cfaf_pkg::BIT_INT_BUS_FAIL]         = internal_bus_fail_alert;
		ALERT_FLAGS[cfaf_pkg::BIT_OSC_DRIFT]            = fast_osc_drift_alert;
		ALERT_FLAGS[cfaf_pkg::BIT_SCLK_COUNT]           = spi_clock_count_alert;
		ALERT_FLAGS[cfaf_pkg::BIT_SPI_SUMMARY]          = spi_error_summary_alert;
	end

	// The CRC flag has no place in the flag byte and leaves on a port of its own.
	assign SPI_CRC_FAULT_FLAG = spi_crc_fault_flag;

endmodule

// file: bench/cfaf_checker.sv
/*
 * Concurrent checks on the ports of the communication fault alert flag block.
 * Assumes every watched signal belongs to CORE_CLK; it is bound to cfaf_top.
 */
`timescale 1ns/100ps

module cfaf_checker #(
	parameter int unsigned OSC_EXPECTED_COUNT = cfaf_pkg::OSC_EXPECTED_COUNT
) (
	// Clock, reset and mode.
	input wire logic                               CORE_CLK,
	input wire logic                               RESET,
	input wire logic                               HOST_IF_SELECT,
	// I2C error bits and their mask.
	input wire logic [cfaf_pkg::I2C_ERR_WIDTH-1:0] I2C_STATUS,
	input wire logic [cfaf_pkg::I2C_ERR_WIDTH-1:0] I2C_ALERT_ENABLE,
	// Fault events and protected writes.
	input wire logic                               INT_BUS_FAIL,
	input wire logic                               SPI_CRC_ERR,
	input wire logic                               SPI_RW_ERR,
	input wire logic                               SPI_TIMEOUT_ERR,
	input wire logic                               PROT_WRITE_REQ,
	input wire logic                               SCAN_ACTIVE,
	input wire logic                               BALANCE_ACTIVE,
	input wire logic                               PROT_WRITE_ACCEPT,
	// Flag writes and flag outputs.
	input wire logic                               FLAG_WRITE,
	input wire logic [cfaf_pkg::FLAG_WIDTH-1:0]    FLAG_WRITE_DATA,
	input wire logic [cfaf_pkg::FLAG_WIDTH-1:0]    ALERT_FLAGS,
	input wire logic                               SPI_CRC_FAULT_FLAG,
	input wire logic                               STAT_BIT1
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	logic spi_mode;
	logic no_spi_err;

	// Mode and quiet-event helpers used by the properties below.
	assign spi_mode = HOST_IF_SELECT == cfaf_pkg::HOST_IF_SPI;
	assign no_spi_err = !SPI_CRC_ERR && !SPI_RW_ERR && !SPI_TIMEOUT_ERR;

	stat_bit_a: assert property (
		STAT_BIT1 == |ALERT_FLAGS[6:4]) else $error("status bit differs from its three alerts");
	i2c_or_a: assert property (
		ALERT_FLAGS[2] == |($past(I2C_STATUS) & $past(I2C_ALERT_ENABLE)))
		else $error("I2C fault flag is not the masked OR");
	accept_a: assert property (
		PROT_WRITE_REQ && !SCAN_ACTIVE && !BALANCE_ACTIVE |=> PROT_WRITE_ACCEPT)
		else $error("free protected write not accepted");
	reject_a: assert property (
		PROT_WRITE_REQ && (SCAN_ACTIVE || BALANCE_ACTIVE) |=> !PROT_WRITE_ACCEPT && ALERT_FLAGS[0])
		else $error("blocked protected write not rejected");
	accept_cause_a: assert property (
		PROT_WRITE_ACCEPT |-> $past(PROT_WRITE_REQ) && !$past(SCAN_ACTIVE) && !$past(BALANCE_ACTIVE))
		else $error("accept without a free request");
	reject_clear_a: assert property (
		FLAG_WRITE && !FLAG_WRITE_DATA[0] && !PROT_WRITE_REQ |=> !ALERT_FLAGS[0])
		else $error("reject flag not cleared by a zero");
	summary_clear_a: assert property (
		FLAG_WRITE && !FLAG_WRITE_DATA[7] && no_spi_err |=> !ALERT_FLAGS[7] && !SPI_CRC_FAULT_FLAG)
		else $error("summary write of zero left an error");
	crc_only_a: assert property (
		spi_mode && SPI_CRC_ERR && !SPI_RW_ERR && !SPI_TIMEOUT_ERR && !ALERT_FLAGS[7]
		|=> SPI_CRC_FAULT_FLAG && !ALERT_FLAGS[7]) else $error("CRC error routed wrongly");
	int_bus_a: assert property (
		spi_mode && INT_BUS_FAIL |=> ALERT_FLAGS[4]) else $error("bus failure not flagged");
	mode_gate_a: assert property (
		(!spi_mode) [*2] |-> ALERT_FLAGS[6:4] == 3'h0) else $error("SPI alerts active outside SPI mode");
	count_hold_a: assert property (
		spi_mode && FLAG_WRITE && FLAG_WRITE_DATA[6] && ALERT_FLAGS[6] |=> ALERT_FLAGS[6])
		else $error("written one changed the clock count alert");
	drift_hold_a: assert property (
		spi_mode && FLAG_WRITE && FLAG_WRITE_DATA[5] && ALERT_FLAGS[5] |=> ALERT_FLAGS[5])
		else $error("written one changed the drift alert");

	// Main scenarios reached.
	accept_c: cover property (PROT_WRITE_ACCEPT);
	count_c: cover property (ALERT_FLAGS[6]);
	drift_c: cover property (ALERT_FLAGS[5]);
endmodule

bind cfaf_top cfaf_checker #(.OSC_EXPECTED_COUNT(OSC_EXPECTED_COUNT)) chk_u (
	.CORE_CLK, .RESET, .HOST_IF_SELECT, .I2C_STATUS, .I2C_ALERT_ENABLE, .INT_BUS_FAIL,
	.SPI_CRC_ERR, .SPI_RW_ERR, .SPI_TIMEOUT_ERR, .PROT_WRITE_REQ, .SCAN_ACTIVE,
	.BALANCE_ACTIVE, .PROT_WRITE_ACCEPT, .FLAG_WRITE, .FLAG_WRITE_DATA, .ALERT_FLAGS,
	.SPI_CRC_FAULT_FLAG, .STAT_BIT1);

// file: bench/cfaf_spi_host.sv
/*
 * Host controller model for the SPI link: it sends frames of a chosen number
 * of serial clocks at a 64 ns period. Assumes the caller spaces its frames.
 */
`timescale 1ns/100ps

module cfaf_spi_host (
	// Link pins toward the device.
	output logic sclk,
	output logic cs_n
);
	// The link clock stands still low and the frame is idle until a send.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	// Sends one frame; a wrong count is only ever commanded by the bench.
	task automatic send(input int n);
		#13 cs_n = 1'b0;
		repeat (n) begin
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		#32 cs_n = 1'b1;
	endtask
endmodule

// file: bench/tb_comm_fault_alert_flags.sv
/*
 * Self-checking bench for the communication fault alert flags.
 * Assumes the checker is bound to cfaf_top and the host model drives the link.
 */
`timescale 1ns/100ps

module tb_comm_fault_alert_flags;
	logic       clk = 1'b0;
	logic       rst, sclk, cs_n, fast = 1'b0, slow = 1'b0, sel, bus, crc, rw, tmo;
	logic       preq, scan, bal, acc, fwr, crcf, stat1;
	logic [8:0] i2c_st, i2c_en;
	logic [7:0] fdata, flags;
	int         err_count, num_checks, fast_half = 50;

	// Core clock, and oscillators giving 20 fast edges per two slow cycles.
	always #5 clk = ~clk;
	always #(fast_half) fast = ~fast;
	always #500 slow = ~slow;

	cfaf_top #(.OSC_EXPECTED_COUNT(20)) dut_u (
		.CORE_CLK(clk), .RESET(rst), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .FAST_OSC_IN(fast),
		.SLOW_OSC_IN(slow), .HOST_IF_SELECT(sel), .I2C_STATUS(i2c_st),
		.I2C_ALERT_ENABLE(i2c_en), .INT_BUS_FAIL(bus), .SPI_CRC_ERR(crc), .SPI_RW_ERR(rw),
		.SPI_TIMEOUT_ERR(tmo), .PROT_WRITE_REQ(preq), .SCAN_ACTIVE(scan),
		.BALANCE_ACTIVE(bal), .PROT_WRITE_ACCEPT(acc), .FLAG_WRITE(fwr),
		.FLAG_WRITE_DATA(fdata), .ALERT_FLAGS(flags), .SPI_CRC_FAULT_FLAG(crcf),
		.STAT_BIT1(stat1));
	cfaf_spi_host host_u (.sclk(sclk), .cs_n(cs_n));

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Writes the flag byte; the update has landed when the task returns.
	task automatic wr(input logic [7:0] d);
		@(negedge clk) fwr = 1'b1;
		fdata = d;
		@(negedge clk) fwr = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask

	// Frames of 32, 31, 33 and no serial clocks, each cleared before the next.
	task automatic t_frames();
		int n[4] = '{32, 31, 33, 0};
		foreach (n[i]) begin
			host_u.send(n[i]);
			idle(6);
			check("count alert", 9'(n[i] != 32), flags[6]);
			check("status bit", 9'(n[i] != 32), stat1);
			wr(8'hFF);
			check("count hold", 9'(n[i] != 32), flags[6]);
			wr(8'hBF);
			check("count clear", 9'h000, flags[6]);
		end
		$display("test frames done");
	endtask
	// Internal bus failure, held by a one and cleared by a zero.
	task automatic t_bus();
		pulse(bus);
		check("bus alert", 9'h001, flags[4]);
		check("status bit", 9'h001, stat1);
		wr(8'hFF);
		check("bus hold", 9'h001, flags[4]);
		wr(8'hEF);
		check("bus clear", 9'h000, {flags[4], stat1});
		$display("test bus done");
	endtask
	// CRC stays out of the summary; a zero to the summary clears all.
	task automatic t_summary();
		pulse(crc);
		check("crc flag", 9'h001, crcf);
		check("summary", 9'h000, flags[7]);
		wr(8'h7F);
		check("crc clear", 9'h000, crcf);
		pulse(rw);
		check("summary rw", 9'h001, flags[7]);
		wr(8'h7F);
		pulse(tmo);
		check("summary timeout", 9'h001, flags[7]);
		pulse(crc);
		wr(8'hFF);
		check("summary hold", 9'h003, {flags[7], crcf});
		wr(8'h7F);
		check("summary clear", 9'h000, {flags[7], crcf});
		$display("test summary done");
	endtask
	// Each I2C error bit, enabled and masked; writes leave the flag alone.
	task automatic t_i2c();
		for (int i = 0; i < 9; i++) begin
			i2c_st = 9'h001 << i;
			i2c_en = 9'h1FF;
			idle(2);
			check("i2c set", 9'h004, flags[3:0]);
			wr(8'h00);
			check("i2c read only", 9'h001, flags[2]);
			i2c_en = ~(9'h001 << i);
			idle(2);
			check("i2c masked", 9'h000, flags[2]);
		end
		i2c_st = 9'h000;
		i2c_en = 9'h000;
		$display("test i2c done");
	endtask
	// Protected writes in every scan and balancing combination.
	task automatic t_prot();
		for (int k = 0; k < 4; k++) begin
			scan = k[0];
			bal = k[1];
			pulse(preq);
			check("accept", 9'(k == 0), acc);
			check("reject", 9'(k != 0), flags[0]);
			wr(8'hFF);
			check("reject hold", 9'(k != 0), flags[0]);
			wr(8'hFE);
			check("reject clear", 9'h000, flags[0]);
		end
		scan = 1'b0;
		bal = 1'b0;
		$display("test protect done");
	endtask
	// Outside SPI mode a bad frame and a bus failure raise nothing.
	task automatic t_mode();
		sel = 1'b1;
		idle(2);
		host_u.send(31);
		pulse(bus);
		idle(6);
		check("mode gate", 9'h000, flags[6:4]);
		sel = 1'b0;
		idle(2);
		pulse(bus);
		check("mode back", 9'h001, flags[4]);
		wr(8'hEF);
		$display("test mode done");
	endtask
	// Fast and slow drift; the clear waits until the drift is gone.
	task automatic t_drift();
		int h[2] = '{40, 60};
		foreach (h[i]) begin
			fast_half = h[i];
			idle(500);
			check("drift set", 9'h003, {flags[5], stat1});
			wr(8'hDF);
			check("drift clear refused", 9'h001, flags[5]);
			wr(8'hFF);
			check("drift hold", 9'h001, flags[5]);
			fast_half = 50;
			idle(600);
			wr(8'hDF);
			check("drift clear", 9'h000, flags[5]);
		end
		$display("test drift done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence after ten cycles of reset.
	initial begin
		{rst, sel, bus, crc, rw, tmo, preq, scan, bal, fwr} = 10'h200;
		{i2c_st, i2c_en, fdata} = 26'h0000000;
		repeat (10) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		idle(3);
		t_frames();
		t_bus();
		t_summary();
		t_i2c();
		t_prot();
		t_mode();
		t_drift();
		complete_run();
	end

	// Cuts a hang short well after the expected run length.
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
endmodule
